// ==== bench/mfid_checker.sv ====
// Assertions on the decoder command outputs
`timescale 1ns/100ps
`default_nettype none
module mfid_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Drive state
  input wire logic jog_active,
  input wire logic run_cmd,
  input wire logic fault_present,
  // Commands
  input wire logic stop_req_ff,
  input wire logic run_inhibit_ff,
  input wire logic jog_reverse_ff,
  input wire logic fault_reset_ff,
  input wire logic [1:0] analog_src_ff,
  input wire logic shutoff_ff,
  input wire logic restart_zero_ff,
  input wire logic index_hold_ff,
  input wire logic index_decel_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_stop_inhibit; $rose(stop_req_ff) |-> ##[0:1] run_inhibit_ff; endproperty
  a_stop_inhibit: assert property (p_stop_inhibit) else $error("stop without inhibit");
  property p_inhibit_run; $fell(run_inhibit_ff) |-> $past(run_cmd); endproperty
  a_inhibit_run: assert property (p_inhibit_run) else $error("inhibit left without run");
  property p_jog; !jog_active ##1 !jog_active |-> !jog_reverse_ff; endproperty
  a_jog: assert property (p_jog) else $error("reverse outside jog");
  property p_rst_pulse; fault_reset_ff |=> !fault_reset_ff; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  // Reset must wait until the fault has gone
  property p_rst_fault; fault_present ##1 fault_present |-> !fault_reset_ff; endproperty
  a_rst_fault: assert property (p_rst_fault) else $error("reset during fault");
  property p_rz_pulse; restart_zero_ff |=> !restart_zero_ff; endproperty
  a_rz_pulse: assert property (p_rz_pulse) else $error("restart pulse too long");
  property p_rz_shut; restart_zero_ff |-> !shutoff_ff; endproperty
  a_rz_shut: assert property (p_rz_shut) else $error("restart while shut off");
  property p_analog; analog_src_ff != 2'h3; endproperty
  a_analog: assert property (p_analog) else $error("bad analog source");
  property p_idx_excl; !(index_hold_ff && index_decel_ff); endproperty
  a_idx_excl: assert property (p_idx_excl) else $error("hold and decel together");
  property p_idx_order; $rose(index_decel_ff) |-> $past(index_hold_ff); endproperty
  a_idx_order: assert property (p_idx_order) else $error("decel without hold");
endmodule // mfid_checker
bind mfid_top mfid_checker mfid_checker_i (.*);
`default_nettype wire

// ==== bench/mfid_switches.sv ====
// External contacts with chatter after every change
`timescale 1ns/100ps
`default_nettype none
module mfid_switches #(parameter int BOUNCE = 3) (
  // Clock
  input wire logic clk_sys,
  // Wanted levels, 1 = closed
  input wire logic [5:0] want,
  // Contacts at the terminals
  output logic [5:0] term
);
  logic [5:0] last = 6'h00;
  logic [5:0] old = 6'h00;
  logic [2:0] left = 3'h0;
  initial term = 6'h00;
  // Glitches are one cycle wide, so only a filter that ignores raw samples stays quiet
  always @(posedge clk_sys) begin
    if (want != last) begin
      old <= last;
      last <= want;
      left <= 3'(BOUNCE);
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
    term <= (left != 3'h0 && left[0]) ? old : last;
  end
endmodule // mfid_switches
`default_nettype wire

// ==== bench/mfid_top_tb.sv ====
// Testbench for the multifunction input decoder
`timescale 1ns/100ps
`default_nettype none
module mfid_top_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic jog_active = 1'b0, run_cmd = 1'b0, stop_cmd = 1'b0, fault_present = 1'b0, index_at_target = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [5:0] want = 6'h00;
  wire [5:0] term;
  wire input_terminal_1 = term[0];
  wire input_terminal_2 = term[1];
  wire input_terminal_3 = term[2];
  wire input_terminal_4 = term[3];
  wire input_terminal_5 = term[4];
  wire input_terminal_6 = term[5];
  wire [15:0] reg_rdata_ff, step_freq_ff;
  wire [1:0] analog_src_ff, accel_set_ff;
  wire [3:0] speed_index_ff;
  wire stop_req_ff, run_inhibit_ff, param_lock_ff, pid_disable_ff, jog_reverse_ff, fault_reset_ff;
  wire freq_src2_ff, oper_src2_ff, plc_run_ff, shutoff_ff, restart_zero_ff, index_hold_ff, index_decel_ff;
  int fails = 0, checks_done = 0, cycles = 0, n_rst = 0, n_rz = 0, b;

  // Short debounce unit keeps the run brief
  mfid_top #(.DEB_UNIT_CYC(4)) mfid_top_i (.*);
  mfid_switches mfid_switches_i (.clk_sys(clk_sys), .want(want), .term(term));

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (fault_reset_ff === 1'b1) n_rst++;
    if (restart_zero_ff === 1'b1) n_rz++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rc(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata_ff, e);
  endtask

  // Long enough for chatter, debounce and the output stage
  task set(input logic [5:0] w);
    @(posedge clk_sys);
    want <= w;
    cyc(20);
  endtask

  initial begin
    cyc(3);
    resetn <= 1'b1;
    rc(6'h06, 16'h0001);
    rc(6'h07, 16'h00c8);
    rc(6'h08, 16'h0708);
    rc(6'h09, 16'h0000);
    wr(6'h0a, 16'h0002);
    rc(6'h0a, 16'h0002);
    rc(6'h1f, 16'h0000);
    wr(6'h07, 16'h0003);
    wr(6'h3f, 16'h0005);
    rc(6'h07, 16'h00c8);
    wr(6'h07, 16'h03e8);
    rc(6'h07, 16'h03e8);
    wr(6'h08, 16'h0e11);
    rc(6'h08, 16'h0708);
    for (int i = 1; i < 16; i++) wr(6'(6'h10 + i), 16'(16'h0100 + i));
    for (int i = 0; i < 4; i++) wr(6'(i), 16'(i + 1));
    wr(6'h04, 16'h0007);
    wr(6'h05, 16'h0008);
    for (int n = 0; n < 64; n++) begin
      set(6'(n));
      chk(speed_index_ff, 16'(n % 16));
      chk(accel_set_ff, 16'(n / 16));
      if (n % 16 != 0) chk(step_freq_ff, 16'(16'h0100 + n % 16));
    end
    set(6'h00);
    wr(6'h00, 16'h001a);
    set(6'h01);
    chk(stop_req_ff, 1'b1);
    set(6'h00);
    chk(run_inhibit_ff, 1'b1);
    run_cmd <= 1'b1;
    cyc(1);
    run_cmd <= 1'b0;
    cyc(3);
    chk(run_inhibit_ff, 1'b0);
    wr(6'h00, 16'h0019);
    cyc(20);
    chk(stop_req_ff, 1'b1);
    set(6'h01);
    chk(stop_req_ff, 1'b0);
    wr(6'h01, 16'h001b);
    set(6'h03);
    chk(param_lock_ff, 1'b1);
    wr(6'h07, 16'h0010);
    rc(6'h07, 16'h03e8);
    set(6'h01);
    wr(6'h02, 16'h001c);
    wr(6'h03, 16'h001d);
    set(6'h0d);
    chk(pid_disable_ff, 1'b1);
    chk(jog_reverse_ff, 1'b0);
    jog_active <= 1'b1;
    cyc(5);
    chk(jog_reverse_ff, 1'b1);
    set(6'h05);
    chk(jog_reverse_ff, 1'b0);
    chk(pid_disable_ff, 1'b1);
    jog_active <= 1'b0;
    wr(6'h04, 16'h0005);
    b = n_rst;
    set(6'h15);
    chk(16'(n_rst - b), 16'h0001);
    set(6'h05);
    fault_present <= 1'b1;
    set(6'h15);
    set(6'h05);
    chk(16'(n_rst - b), 16'h0001);
    fault_present <= 1'b0;
    wr(6'h05, 16'h001e);
    cyc(20);
    chk(16'(n_rst - b), 16'h0002);
    wr(6'h00, 16'h001f);
    wr(6'h01, 16'h0020);
    set(6'h01);
    chk({freq_src2_ff, oper_src2_ff}, 16'h0002);
    set(6'h02);
    chk({freq_src2_ff, oper_src2_ff}, 16'h0001);
    wr(6'h00, 16'h0015);
    wr(6'h01, 16'h0016);
    set(6'h03);
    chk(analog_src_ff, 16'h0000);
    set(6'h01);
    chk(analog_src_ff, 16'h0001);
    set(6'h02);
    chk(analog_src_ff, 16'h0002);
    wr(6'h02, 16'h0021);
    wr(6'h03, 16'h000e);
    set(6'h04);
    set(6'h00);
    chk(plc_run_ff, 1'b1);
    stop_cmd <= 1'b1;
    cyc(3);
    stop_cmd <= 1'b0;
    cyc(3);
    chk(plc_run_ff, 1'b0);
    set(6'h08);
    chk(plc_run_ff, 1'b1);
    set(6'h20);
    chk(plc_run_ff, 1'b0);
    wr(6'h04, 16'h0023);
    wr(6'h05, 16'h0024);
    cyc(20);
    b = n_rz;
    set(6'h30);
    chk(shutoff_ff, 1'b1);
    set(6'h20);
    chk(shutoff_ff, 1'b0);
    chk(16'(n_rz - b), 16'h0001);
    set(6'h00);
    chk(shutoff_ff, 1'b1);
    set(6'h20);
    wr(6'h00, 16'h0022);
    run_cmd <= 1'b1;
    stop_cmd <= 1'b1;
    cyc(5);
    chk(index_hold_ff, 1'b1);
    set(6'h21);
    chk({index_hold_ff, index_decel_ff}, 16'h0001);
    index_at_target <= 1'b1;
    run_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    cyc(5);
    chk(index_decel_ff, 1'b0);
    wr(6'h02, 16'h001c);
    wr(6'h06, 16'h0002);
    wr(6'h06, 16'h0015);
    rc(6'h06, 16'h0002);
    @(posedge clk_sys);
    want <= 6'h24;
    cyc(11);
    chk(pid_disable_ff, 1'b0);
    cyc(9);
    chk(pid_disable_ff, 1'b1);
    for (int i = 0; i < 6; i++) wr(6'(i), 16'h0000);
    set(6'h3f);
    chk({stop_req_ff, param_lock_ff, pid_disable_ff, plc_run_ff, shutoff_ff, freq_src2_ff,
         oper_src2_ff, speed_index_ff, accel_set_ff}, 16'h0000);
    report_and_stop();
  end
endmodule // mfid_top_tb
`default_nettype wire

// ==== hdl/mfid_debounce.v ====
// Per-terminal debounce filter
`timescale 1ns/100ps
`default_nettype none
module mfid_debounce #(
  parameter UNIT_CYC = 20000
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  // Settings
  input wire [4:0] units,
  // Terminal
  input wire raw,
  output reg level_ff
);
  reg [14:0] tick_ff;
  reg [4:0] cnt_ff;
  wire tick = (tick_ff == UNIT_CYC[14:0] - 15'h0001);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 15'h0000;
      cnt_ff <= 5'h00;
      level_ff <= 1'b0;
    end else if (clk_en) begin
      // A differing level must hold for units full ticks; any bounce restarts the wait
      if (raw == level_ff) begin
        tick_ff <= 15'h0000;
        cnt_ff <= 5'h00;
      end else if (tick) begin
        tick_ff <= 15'h0000;
        if (cnt_ff + 5'h01 >= units) begin
          level_ff <= raw; // RULE13
          cnt_ff <= 5'h00;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end else begin
        tick_ff <= tick_ff + 15'h0001;
      end
    end
  end
endmodule // mfid_debounce
`default_nettype wire

// ==== hdl/mfid_defs.vh ====
// Constants for the multifunction input decoder
// Function
// RULE1: Forced stop codes 25/26 stop by configured method, no fault, need new run.
// RULE2: Parameter lock code 27 blocks every parameter write while active.
// RULE3: Code 28 on disables PID regulation.
// RULE4: Code 29 selects reverse when on, forward when off, only during jog.
// RULE5: Code 30 resets faults like code 05 but with open contact active.
// RULE6: Code 31 on selects second frequency source, off the first.
// RULE7: Code 32 on selects second operation source, off the first.
// RULE8: Code 33 pulse starts step program like code 14; stop cancels it.
// RULE9: Shutoff codes 35/36 cut output to coast; later change restarts from 0Hz.
// RULE10: With codes 21 and 22 both on, priority is voltage, current, auxiliary.
// RULE11: Codes 07 low bit, 08 high bit pick accel/decel set 1 to 4.
// RULE12: Speed codes 1-4 form binary index; zero is master, n is step n.
// RULE13: Every terminal debounced by N times 2 ms, N 1 to 20, default 1.
// RULE14: Proximity code 34 indexing holds speed after stop until sensor triggers.
// RULE15: After the trigger decelerate and stop by index angle and decel time.
// RULE16: Gear 4-1000 def 200, angle 0-3600 def 1800, decel 0-10000 def 0.
// RULE17: Fifteen step speeds, 0.01 Hz units, default 0, indexed by speed code.
// RULE18: Code 05 resets drive from fault once condition cleared.
// RULE19: Code 14 runs the step program while asserted.
// RULE20: Code 00 has no effect.
// RULE21: Open variants active on closed contact, closed variants on open contact.
// RULE22: Decoding uses debounced terminal levels only.
`ifndef MFID_DEFS_VH
`define MFID_DEFS_VH
`define MFID_NTERM 6
`define MFID_FN_NONE 6'h00
`define MFID_FN_SPD1 6'h01
`define MFID_FN_SPD2 6'h02
`define MFID_FN_SPD3 6'h03
`define MFID_FN_SPD4 6'h04
`define MFID_FN_RST_NO 6'h05
`define MFID_FN_ADT1 6'h07
`define MFID_FN_ADT2 6'h08
`define MFID_FN_RUNPLC 6'h0e
`define MFID_FN_SRC_CUR 6'h15
`define MFID_FN_SRC_AUX 6'h16
`define MFID_FN_FSTOP_NC 6'h19
`define MFID_FN_FSTOP_NO 6'h1a
`define MFID_FN_PLOCK 6'h1b
`define MFID_FN_PIDOFF 6'h1c
`define MFID_FN_JOGDIR 6'h1d
`define MFID_FN_RST_NC 6'h1e
`define MFID_FN_FSRC2 6'h1f
`define MFID_FN_OSRC2 6'h20
`define MFID_FN_PLC1SHOT 6'h21
`define MFID_FN_PROX 6'h22
`define MFID_FN_SHUT_NO 6'h23
`define MFID_FN_SHUT_NC 6'h24
// Register offsets
`define MFID_A_FUNC0 6'h00
`define MFID_A_DEBOUNCE 6'h06
`define MFID_A_GEAR 6'h07
`define MFID_A_ANGLE 6'h08
`define MFID_A_IDECEL 6'h09
`define MFID_A_STOPM 6'h0a
`define MFID_A_STATUS 6'h0b
`define MFID_A_STEP1 6'h11
`define MFID_A_STEP15 6'h1f
// Ranges and resets
`define MFID_DEB_MIN 5'h01
`define MFID_DEB_MAX 5'h14
`define MFID_DEB_RST 5'h01
`define MFID_GEAR_MIN 16'h0004
`define MFID_GEAR_MAX 16'h03e8
`define MFID_GEAR_RST 16'h00c8
`define MFID_ANGLE_MAX 16'h0e10
`define MFID_ANGLE_RST 16'h0708
`define MFID_IDECEL_MAX 16'h2710
`define MFID_IDECEL_RST 16'h0000
// Timing: debounce unit 2 ms at 100 ns clock
`define MFID_DEB_UNIT_US 2000
`define MFID_CLK_NS 100
`define MFID_DEB_UNIT_CYC ((`MFID_DEB_UNIT_US * 1000) / `MFID_CLK_NS)
`endif

// ==== hdl/mfid_step_mem.v ====
// Step-speed table, registered read
`timescale 1ns/100ps
`default_nettype none
module mfid_step_mem (
  // Clock
  input wire clk_sys,
  input wire clk_en,
  // Write port
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [15:0] wr_data,
  // Read port
  input wire [3:0] rd_idx,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:15];
  integer i;
  // Index 0 unused; all entries start at 0.00 Hz
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[i] = 16'h0000; // RULE17
    end
    rd_data = 16'h0000;
  end
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
    end
  end
endmodule // mfid_step_mem
`default_nettype wire

// ==== hdl/mfid_top.v ====
// Multifunction input decoder top
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "mfid_defs.vh"
module mfid_top #(
  parameter DEB_UNIT_CYC = `MFID_DEB_UNIT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  // Terminals, raw contact closed = 1
  input wire input_terminal_1,
  input wire input_terminal_2,
  input wire input_terminal_3,
  input wire input_terminal_4,
  input wire input_terminal_5,
  input wire input_terminal_6,
  // Drive state
  input wire jog_active,
  input wire run_cmd,
  input wire stop_cmd,
  input wire fault_present,
  input wire index_at_target,
  // Register port
  input wire [5:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // Commands
  output reg stop_req_ff,
  output reg run_inhibit_ff,
  output reg param_lock_ff,
  output reg pid_disable_ff,
  output reg jog_reverse_ff,
  output reg fault_reset_ff,
  output reg freq_src2_ff,
  output reg oper_src2_ff,
  output reg [1:0] analog_src_ff,
  output reg plc_run_ff,
  output reg shutoff_ff,
  output reg restart_zero_ff,
  output reg [1:0] accel_set_ff,
  output reg [3:0] speed_index_ff,
  output reg [15:0] step_freq_ff,
  output reg index_hold_ff,
  output reg index_decel_ff
);
  localparam IX_IDLE = 3'b001;
  localparam IX_HOLD = 3'b010;
  localparam IX_DECEL = 3'b100;

  wire [5:0] raw = {input_terminal_6, input_terminal_5, input_terminal_4,
                    input_terminal_3, input_terminal_2, input_terminal_1};
  wire [5:0] deb;
  reg [5:0] func_ff [0:5];
  reg [4:0] deb_units_ff;
  reg [15:0] gear_ff;
  reg [15:0] angle_ff;
  reg [15:0] idecel_ff;
  reg [1:0] stop_method_ff;
  reg [2:0] ix_state_ff;
  reg [2:0] nxt_ix_state;
  reg shut_prev_ff;
  reg rst_prev_ff;
  reg plc1_prev_ff;
  reg plc_latch_ff;
  reg fstop_prev_ff;
  integer kd;
  integer kp;
  integer kr;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_deb
      mfid_debounce #(
        .UNIT_CYC(DEB_UNIT_CYC)
      ) u_deb (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clk_en(clk_en),
        .units(deb_units_ff),
        .raw(raw[g]),
        .level_ff(deb[g]) // RULE22
      );
    end
  endgenerate

  // Decode: OR of every terminal carrying a code; polarity by variant
  reg f_fstop, f_plock, f_pid, f_jog, f_rst, f_fs2, f_os2, f_cur, f_aux;
  reg f_plc, f_plc1, f_prox, f_shut;
  reg [1:0] f_adt;
  reg [3:0] f_spd;
  always @* begin
    f_fstop = 1'b0;
    f_plock = 1'b0;
    f_pid = 1'b0;
    f_jog = 1'b0;
    f_rst = 1'b0;
    f_fs2 = 1'b0;
    f_os2 = 1'b0;
    f_cur = 1'b0;
    f_aux = 1'b0;
    f_plc = 1'b0;
    f_plc1 = 1'b0;
    f_prox = 1'b0;
    f_shut = 1'b0;
    f_adt = 2'b00;
    f_spd = 4'h0;
    for (kd = 0; kd < 6; kd = kd + 1) begin
      case (func_ff[kd])
        `MFID_FN_SPD1: f_spd[0] = f_spd[0] | deb[kd]; // RULE12
        `MFID_FN_SPD2: f_spd[1] = f_spd[1] | deb[kd];
        `MFID_FN_SPD3: f_spd[2] = f_spd[2] | deb[kd];
        `MFID_FN_SPD4: f_spd[3] = f_spd[3] | deb[kd];
        `MFID_FN_RST_NO: f_rst = f_rst | deb[kd]; // RULE18 RULE21
        `MFID_FN_ADT1: f_adt[0] = f_adt[0] | deb[kd]; // RULE11
        `MFID_FN_ADT2: f_adt[1] = f_adt[1] | deb[kd];
        `MFID_FN_RUNPLC: f_plc = f_plc | deb[kd];
        `MFID_FN_SRC_CUR: f_cur = f_cur | deb[kd];
        `MFID_FN_SRC_AUX: f_aux = f_aux | deb[kd];
        `MFID_FN_FSTOP_NC: f_fstop = f_fstop | ~deb[kd]; // RULE21
        `MFID_FN_FSTOP_NO: f_fstop = f_fstop | deb[kd];
        `MFID_FN_PLOCK: f_plock = f_plock | deb[kd];
        `MFID_FN_PIDOFF: f_pid = f_pid | deb[kd];
        `MFID_FN_JOGDIR: f_jog = f_jog | deb[kd];
        `MFID_FN_RST_NC: f_rst = f_rst | ~deb[kd]; // RULE5
        `MFID_FN_FSRC2: f_fs2 = f_fs2 | deb[kd];
        `MFID_FN_OSRC2: f_os2 = f_os2 | deb[kd];
        `MFID_FN_PLC1SHOT: f_plc1 = f_plc1 | deb[kd];
        `MFID_FN_PROX: f_prox = f_prox | deb[kd];
        `MFID_FN_SHUT_NO: f_shut = f_shut | deb[kd];
        `MFID_FN_SHUT_NC: f_shut = f_shut | ~deb[kd]; // RULE21
        default: f_shut = f_shut; // RULE20
      endcase
    end
  end

  // Indexing configured when any terminal carries the proximity code
  reg prox_cfg;
  always @* begin
    prox_cfg = 1'b0;
    for (kp = 0; kp < 6; kp = kp + 1) begin
      if (func_ff[kp] == `MFID_FN_PROX) begin
        prox_cfg = 1'b1;
      end
    end
  end

  always @* begin
    nxt_ix_state = ix_state_ff;
    case (ix_state_ff)
      IX_IDLE: if (prox_cfg && stop_cmd) nxt_ix_state = IX_HOLD; // RULE14
      IX_HOLD: if (f_prox) nxt_ix_state = IX_DECEL; // RULE14
      IX_DECEL: if (index_at_target) nxt_ix_state = IX_IDLE; // RULE15
      default: nxt_ix_state = IX_IDLE;
    endcase
  end

  // Register writes; lock blocks all of them, including function codes
  wire wr_ok = reg_wr && !param_lock_ff; // RULE2
  wire step_wr = wr_ok && reg_addr >= `MFID_A_STEP1 && reg_addr <= `MFID_A_STEP15;
  wire [15:0] step_rd;
  // Step table is write-only from the bus: its single read port serves the speed lookup
  mfid_step_mem u_mem (
    .clk_sys(clk_sys),
    .clk_en(clk_en),
    .wr_en(step_wr),
    .wr_idx(reg_addr[3:0]),
    .wr_data(reg_wdata),
    .rd_idx(f_spd),
    .rd_data(step_rd)
  );

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (kr = 0; kr < 6; kr = kr + 1) begin
        func_ff[kr] <= `MFID_FN_NONE;
      end
      deb_units_ff <= `MFID_DEB_RST;
      gear_ff <= `MFID_GEAR_RST;
      angle_ff <= `MFID_ANGLE_RST;
      idecel_ff <= `MFID_IDECEL_RST;
      stop_method_ff <= 2'b00;
    end else if (clk_en && wr_ok) begin
      if (reg_addr < `MFID_A_DEBOUNCE) begin
        func_ff[reg_addr[2:0]] <= reg_wdata[5:0];
      end
      case (reg_addr)
        `MFID_A_DEBOUNCE: if (reg_wdata[4:0] >= `MFID_DEB_MIN && reg_wdata[4:0] <= `MFID_DEB_MAX &&
                              reg_wdata[15:5] == 11'h000) deb_units_ff <= reg_wdata[4:0]; // RULE13
        `MFID_A_GEAR: if (reg_wdata >= `MFID_GEAR_MIN && reg_wdata <= `MFID_GEAR_MAX) gear_ff <= reg_wdata; // RULE16
        `MFID_A_ANGLE: if (reg_wdata <= `MFID_ANGLE_MAX) angle_ff <= reg_wdata; // RULE16
        `MFID_A_IDECEL: if (reg_wdata <= `MFID_IDECEL_MAX) idecel_ff <= reg_wdata; // RULE16
        `MFID_A_STOPM: stop_method_ff <= reg_wdata[1:0];
        default: stop_method_ff <= stop_method_ff;
      endcase
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata_ff <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr < `MFID_A_DEBOUNCE) begin
          reg_rdata_ff <= {10'h000, func_ff[reg_addr[2:0]]};
        end else begin
          case (reg_addr)
            `MFID_A_DEBOUNCE: reg_rdata_ff <= {11'h000, deb_units_ff};
            `MFID_A_GEAR: reg_rdata_ff <= gear_ff;
            `MFID_A_ANGLE: reg_rdata_ff <= angle_ff;
            `MFID_A_IDECEL: reg_rdata_ff <= idecel_ff;
            `MFID_A_STOPM: reg_rdata_ff <= {14'h0000, stop_method_ff};
            `MFID_A_STATUS: reg_rdata_ff <= {7'h00, ix_state_ff, deb};
            default: reg_rdata_ff <= 16'h0000;
          endcase
        end
      end
    end
  end

  // Command outputs
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stop_req_ff <= 1'b0;
      run_inhibit_ff <= 1'b0;
      param_lock_ff <= 1'b0;
      pid_disable_ff <= 1'b0;
      jog_reverse_ff <= 1'b0;
      fault_reset_ff <= 1'b0;
      freq_src2_ff <= 1'b0;
      oper_src2_ff <= 1'b0;
      analog_src_ff <= 2'b00;
      plc_run_ff <= 1'b0;
      plc_latch_ff <= 1'b0;
      plc1_prev_ff <= 1'b0;
      shutoff_ff <= 1'b0;
      shut_prev_ff <= 1'b0;
      restart_zero_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
      fstop_prev_ff <= 1'b0;
      accel_set_ff <= 2'b00;
      speed_index_ff <= 4'h0;
      step_freq_ff <= 16'h0000;
      ix_state_ff <= IX_IDLE;
      index_hold_ff <= 1'b0;
      index_decel_ff <= 1'b0;
    end else if (clk_en) begin
      // Stop method itself lives downstream; this block only raises the request
      stop_req_ff <= f_fstop; // RULE1
      fstop_prev_ff <= f_fstop;
      if (f_fstop) begin
        run_inhibit_ff <= 1'b1; // RULE1
      end else if (run_cmd && !fstop_prev_ff) begin
        run_inhibit_ff <= 1'b0;
      end
      param_lock_ff <= f_plock; // RULE2
      pid_disable_ff <= f_pid; // RULE3
      jog_reverse_ff <= jog_active & f_jog; // RULE4
      rst_prev_ff <= f_rst;
      fault_reset_ff <= f_rst & ~rst_prev_ff & ~fault_present; // RULE18 RULE5
      freq_src2_ff <= f_fs2; // RULE6
      oper_src2_ff <= f_os2; // RULE7
      // 0 voltage, 1 current, 2 auxiliary
      if (f_cur && f_aux) begin
        analog_src_ff <= 2'b00; // RULE10
      end else if (f_cur) begin
        analog_src_ff <= 2'b01;
      end else if (f_aux) begin
        analog_src_ff <= 2'b10;
      end else begin
        analog_src_ff <= 2'b00;
      end
      plc1_prev_ff <= f_plc1;
      if (stop_cmd) begin
        plc_latch_ff <= 1'b0; // RULE8
      end else if (f_plc1 && !plc1_prev_ff) begin
        plc_latch_ff <= 1'b1; // RULE8
      end
      plc_run_ff <= f_plc | (plc_latch_ff & ~stop_cmd); // RULE19
      shut_prev_ff <= f_shut;
      shutoff_ff <= f_shut; // RULE9
      restart_zero_ff <= shut_prev_ff & ~f_shut; // RULE9
      accel_set_ff <= f_adt; // RULE11
      speed_index_ff <= f_spd; // RULE12
      // Lags the speed index by one cycle through the registered table read
      step_freq_ff <= step_rd; // RULE17
      ix_state_ff <= nxt_ix_state;
      index_hold_ff <= nxt_ix_state == IX_HOLD; // RULE14
      index_decel_ff <= nxt_ix_state == IX_DECEL; // RULE15
    end
  end
endmodule // mfid_top
`default_nettype wire
